// ---- bench/fco_bs_model.sv ----
`timescale 1ns/1ps
module fco_bs_model (
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_b,
	// Offsets from the controller
	input  wire logic                      i_deliver,
	input  wire logic [7:0]                i_frame_offset,
	input  wire logic [fco_pkg::CHIP_W-1:0] i_chip_offset,
	input  wire logic [2:0]                i_link_idx,
	// Terminal side
	input  wire logic                      i_frame_tick,
	input  wire logic [fco_pkg::SFN_W-1:0] i_sfn,
	input  wire logic [fco_pkg::DOFF_W-1:0] i_doff,
	input  wire logic                      i_tdd,
	// Applied downlink timing
	output logic      [fco_pkg::TOT_W-1:0] o_dl_timing,
	output logic      [2:0]                o_cell,
	output logic      [7:0]                o_count,
	// Terminal counters
	output logic      [7:0]                o_ue_cfn,
	output logic      [7:0]                o_ue_cmn
);
	import fco_pkg::*;

	logic [TOT_W-1:0] raw;
	logic [TOT_W-1:0] dfr;

	// Whole frames covered by the DOFF chips
	assign dfr = (TOT_W'(i_doff) << DOFF_SHIFT) / CHIPS_PER_FRAME;

	// Terminal CFN: set on each offset delivery, then per frame
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_ue_cfn <= '0;
		end else if (i_deliver && i_tdd) begin
			o_ue_cfn <= i_sfn[7:0] - i_doff[7:0];
		end else if (i_deliver) begin
			o_ue_cfn <= i_sfn[7:0] - dfr[7:0];
		end else if (i_frame_tick) begin
			o_ue_cfn <= o_ue_cfn + 8'h01;
		end
	end

	// Terminal common CFN follows the cell SFN in every state
	assign o_ue_cmn = i_sfn[7:0];

	// Frame and chip offsets as one chip count
	assign raw = TOT_W'(i_frame_offset) * CHIPS_PER_FRAME
		+ TOT_W'(i_chip_offset);

	// Timing applied to the cell, snapped to a 256 chip grid
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_dl_timing <= '0;
			o_cell      <= '0;
			o_count     <= '0;
		end else if (i_deliver) begin
			o_dl_timing <= (raw + 24'h000080) & 24'hFFFF00;
			o_cell      <= i_link_idx;
			o_count     <= o_count + 8'h01;
		end
	end
endmodule

// ---- bench/fco_top_tb.sv ----
`timescale 1ns/1ps
module fco_top_tb;
	import fco_pkg::*;

	logic              clk;
	logic              rst_b;
	logic              tick;
	logic [7:0]        addr;
	logic [31:0]       wdata;
	logic              wen;
	logic              ren;
	logic [31:0]       rdata;
	logic [7:0]        fo;
	logic [CHIP_W-1:0] co;
	logic [2:0]        idx;
	logic              dlv;
	logic              busy;
	logic [CFN_W-1:0]  cfn;
	logic [SFN_W-1:0]  sfn;
	logic [TOT_W-1:0]  bs_time;
	logic [2:0]        bs_cell;
	logic [7:0]        bs_count;
	logic [7:0]        ue_cfn;
	logic [7:0]        ue_cmn;
	logic [DOFF_W-1:0] ue_doff;
	logic              ue_tdd;
	logic [2:0]        bad [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
	int                num_errors;
	int                checked;

	fco_top #(.SFN_MOD(4096)) i_dut (
		.i_clk(clk), .i_rst_b(rst_b), .i_frame_tick(tick),
		.i_addr(addr), .i_wr_data(wdata), .i_wr_en(wen), .i_rd_en(ren),
		.o_rd_data(rdata), .o_frame_offset(fo), .o_chip_offset(co),
		.o_link_idx(idx), .o_deliver(dlv), .o_busy(busy),
		.o_cfn(cfn), .o_sfn(sfn)
	);

	fco_bs_model i_bs (
		.i_clk(clk), .i_rst_b(rst_b), .i_deliver(dlv),
		.i_frame_offset(fo), .i_chip_offset(co), .i_link_idx(idx),
		.i_frame_tick(tick), .i_sfn(sfn), .i_doff(ue_doff),
		.i_tdd(ue_tdd), .o_dl_timing(bs_time), .o_cell(bs_cell),
		.o_count(bs_count), .o_ue_cfn(ue_cfn), .o_ue_cmn(ue_cmn)
	);

	// Clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict();
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask

	task automatic cmp_res(input fco_result_type got,
		input fco_result_type exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: offsets got %h exp %h", $time, got,
				exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wen   <= 1'b1;
		@(posedge clk);
		wen   <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		ren  <= 1'b1;
		@(posedge clk);
		ren  <= 1'b0;
		#1;
		cmp_word(rdata, e, "read");
	endtask

	task automatic pulse_frame();
		@(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		#1;
	endtask

	// Expected offsets worked out from the frame arithmetic
	function automatic fco_result_type exp_res(input logic [3:0] ctl,
		input logic [9:0] doff, input logic [26:0] lk, input logic [2:0] op);
		fco_result_type r;
		logic [31:0]    tot;
		logic           use_lk;
		r.idx  = lk[26:24];
		use_lk = op == 3'h2 || op == 3'h4 || (op == 3'h3 && ctl[3]);
		if (ctl[0]) begin
			r.frame = (op == 3'h3 && ctl[3]) ? lk[7:0] : doff[7:0];
			r.chip  = '0;
		end else begin
			tot = {22'h000000, doff} * 32'h00000200
				+ (use_lk ? lk[7:0] * 32'h00009600 + lk[23:8] : 32'h00000000)
				+ (ctl[2] ? 32'h00000100 : 32'h00000000);
			r.frame = 8'(tot / 32'h00009600);
			r.chip  = 16'(tot % 32'h00009600);
		end
		return r;
	endfunction

	// One offset calculation, with a refused command while busy in FDD
	task automatic run_cmd(input logic [3:0] ctl, input logic [9:0] doff,
		input logic [26:0] lk, input logic [2:0] op);
		fco_result_type e;
		fco_result_type g;
		logic [23:0]    rt;
		logic [7:0]     cnt;
		logic [7:0]     ue;
		int             n;
		e   = exp_res(ctl, doff, lk, op);
		g   = e;
		if (!ctl[1])
			g.frame = 8'h00;
		ue  = ctl[0] ? 8'h00 - doff[7:0]
			: 8'h00 - 8'(({22'h000000, doff} * 32'h200) / 32'h9600);
		rt  = (24'(g.frame) * 24'h009600 + 24'(g.chip) + 24'h000080)
			& 24'hFFFF00;
		cnt = bs_count + 8'h01;
		n   = 0;
		ue_doff <= doff;
		ue_tdd  <= ctl[0];
		wr(OFS_CTRL, {28'h0000000, ctl});
		wr(OFS_DOFF, {22'h000000, doff});
		wr(OFS_LINK, {5'h00, lk});
		wr(OFS_CMD, {29'h00000000, op});
		#1;
		cmp_word(32'(busy), 32'h00000001, "busy");
		if (!ctl[0]) begin
			wr(OFS_CMD, 32'h00000001);
			n = 2;
			#1;
		end
		while (dlv !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp_word(32'(n), ctl[0] ? 32'h2 : 32'h1C, "latency");
		cmp_res({idx, co, fo}, g);
		cmp_word(32'(busy), 32'h00000000, "busy end");
		rd(OFS_RESULT, {5'h00, e});
		rd(OFS_STATUS, 32'h00000000);
		cmp_word(32'(bs_time), 32'(rt), "bs timing");
		cmp_word(32'(bs_cell), 32'(e.idx), "cell");
		cmp_word(32'(bs_count), 32'(cnt), "count");
		cmp_word(32'(ue_cfn), 32'(ue), "ue cfn");
	endtask

	// Main sequence
	initial begin
		rst_b      = 1'b0;
		tick       = 1'b0;
		addr       = 8'h00;
		wdata      = 32'h00000000;
		wen        = 1'b0;
		ren        = 1'b0;
		ue_doff    = 10'h000;
		ue_tdd     = 1'b0;
		num_errors = 0;
		checked    = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values, one unmapped place included
		for (int a = 0; a <= 32; a += 4)
			rd(8'(a), 32'h00000000);
		run_cmd(4'h2, 10'h3FF, 27'h0000000, 3'h1);
		run_cmd(4'h6, 10'h04B, 27'h1000000, 3'h1);
		run_cmd(4'h2, 10'h3FF, 27'h595FFFF, 3'h2);
		run_cmd(4'hA, 10'h010, 27'h2001203, 3'h3);
		run_cmd(4'h2, 10'h010, 27'h2001203, 3'h3);
		run_cmd(4'h6, 10'h100, 27'h3004007, 3'h4);
		run_cmd(4'h0, 10'h3FF, 27'h4000000, 3'h1);
		run_cmd(4'h3, 10'h3FF, 27'h6000000, 3'h1);
		run_cmd(4'hB, 10'h021, 27'h700005A, 3'h3);
		run_cmd(4'h3, 10'h021, 27'h700005A, 3'h3);
		run_cmd(4'h3, 10'h022, 27'h1000011, 3'h4);
		run_cmd(4'h1, 10'h033, 27'h5000044, 3'h2);
		// Undefined operation codes start nothing
		foreach (bad[i]) begin
			wr(OFS_CMD, {29'h00000000, bad[i]});
			#1;
			cmp_word({31'h00000000, busy}, 32'h00000000, "bad op");
		end
		repeat (32) @(posedge clk);
		#1;
		cmp_word({24'h000000, bs_count}, 32'h0000000C, "runs");
		// Counters in the common state, then wraps
		wr(OFS_CTRL, 32'h00000000);
		wr(OFS_SFN, 32'h000000FF);
		#1;
		cmp_word({20'h00000, sfn}, 32'h000000FF, "sfn load");
		cmp_word({24'h000000, cfn}, 32'h000000FF, "cfn load");
		pulse_frame();
		cmp_word({24'h000000, cfn}, 32'h00000000, "cfn wrap");
		cmp_word({20'h00000, sfn}, 32'h00000100, "sfn step");
		wr(OFS_SFN, 32'h00000FFF);
		pulse_frame();
		cmp_word({20'h00000, sfn}, 32'h00000000, "sfn wrap");
		// Dedicated state, then back to common
		wr(OFS_CTRL, 32'h00000002);
		wr(OFS_SFN, 32'h00000123);
		#1;
		cmp_word({24'h000000, cfn}, 32'h00000000, "cfn kept");
		pulse_frame();
		pulse_frame();
		cmp_word({24'h000000, cfn}, 32'h00000002, "cfn step");
		wr(OFS_CTRL, 32'h00000000);
		#1;
		cmp_word({24'h000000, cfn}, 32'h00000025, "cfn reload");
		cmp_word(32'(cfn), 32'(ue_cmn), "cmn cfn");
		rd(OFS_SFN, 32'h00000125);
		rd(OFS_CFN, 32'h00000025);
		cmp_word(32'(ue_cfn), 32'h000000D1, "ue step");
		give_verdict();
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
endmodule

// ---- verilog/fco_counter.sv ----
`timescale 1ns/1ps
module fco_counter #(
	parameter int W   = 8,
	parameter int MOD = 256
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	// Control
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_load_val,
	input  wire logic         i_step,
	// Count
	output logic      [W-1:0] o_count
);

	localparam logic [W-1:0] LAST = W'(MOD - 1);

	// Refuse a modulus the counter cannot hold
	generate
		if (MOD < 2 || MOD > (1 << W)) begin : g_bad_mod
			$error("fco_counter: modulus out of range");
		end
	endgenerate

	// Load wins over step; wrap after the last value
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_count <= '0;
		end else if (i_load) begin
			o_count <= i_load_val;
		end else if (i_step) begin
			if (o_count == LAST) begin
				o_count <= '0;
			end else begin
				o_count <= o_count + W'(1);
			end
		end
	end

endmodule

// ---- verilog/fco_divider.sv ----
`timescale 1ns/1ps
module fco_divider #(
	parameter int W       = 24,
	parameter int DW      = 16,
	parameter int DIVISOR = 38400
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst_b,
	// Request
	input  wire logic          i_start,
	input  wire logic [W-1:0]  i_dividend,
	// Answer
	output logic      [W-1:0]  o_quot,
	output logic      [DW-1:0] o_rem,
	output logic               o_done
);

	localparam logic [DW:0] DIV_C = (DW + 1)'(DIVISOR);

	logic [$clog2(W+1)-1:0] cnt_reg;
	logic                   busy_reg;
	logic [DW:0]            trial;
	logic                   ge;

	// Refuse a divisor that does not fit the remainder
	generate
		if (DIVISOR < 1 || DIVISOR >= (1 << DW)) begin : g_bad_div
			$error("fco_divider: divisor out of range");
		end
	endgenerate

	// Shift in the next dividend bit and compare
	always_comb begin
		trial = {o_rem, o_quot[W-1]};
		ge    = (trial >= DIV_C);
	end

	// Restoring division, one quotient bit per cycle
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			o_done   <= 1'b0;
			o_quot   <= '0;
			o_rem    <= '0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !busy_reg) begin
				o_quot   <= i_dividend;
				o_rem    <= '0;
				cnt_reg  <= ($clog2(W+1))'(W);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				o_quot  <= {o_quot[W-2:0], ge};
				o_rem   <= ge ? DW'(trial - DIV_C) : trial[DW-1:0];
				cnt_reg <= cnt_reg - ($clog2(W+1))'(1);
				if (cnt_reg == ($clog2(W+1))'(1)) begin
					busy_reg <= 1'b0;
					o_done   <= 1'b1;
				end
			end
		end
	end

endmodule

// ---- verilog/fco_pkg.sv ----
package fco_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DOFF   = 8'h04;
	localparam logic [7:0] OFS_LINK   = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_SFN    = 8'h18;
	localparam logic [7:0] OFS_CFN    = 8'h1C;

	// Control register bit positions
	localparam int CTRL_TDD   = 0;
	localparam int CTRL_DED   = 1;
	localparam int CTRL_HALF  = 2;
	localparam int CTRL_KNOWN = 3;

	// Field widths
	localparam int DOFF_W = 10;
	localparam int SFN_W  = 12;
	localparam int CFN_W  = 8;
	localparam int TOT_W  = 24;
	localparam int CHIP_W = 16;

	// Frame arithmetic constants
	localparam logic [TOT_W-1:0] CHIPS_PER_FRAME = 24'h009600;
	localparam int               DOFF_SHIFT      = 9;
	localparam logic [TOT_W-1:0] HALF_STEP       = 24'h000100;
	localparam logic [TOT_W-1:0] FO_WRAP_CHIPS   = 24'h960000;
	localparam int               SFN_MOD_DEF     = 4096;
	localparam int               CFN_MOD         = 256;
	localparam logic [7:0]       CMN_FRAME_OFS   = 8'h00;

	// Reset values
	localparam logic [DOFF_W-1:0] RST_DOFF = 10'h000;
	localparam logic [SFN_W-1:0]  RST_SFN  = 12'h000;
	localparam logic [CFN_W-1:0]  RST_CFN  = 8'h00;

	// Offset calculation commands
	typedef enum logic [2:0] {
		CMD_NONE      = 3'h0,
		CMD_SINGLE    = 3'h1,
		CMD_MULTI     = 3'h2,
		CMD_TARGET    = 3'h3,
		CMD_INTER_RAN = 3'h4
	} fco_cmd_type;

	// Sequencer states, Gray coded around the loop
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_START = 2'h1,
		ST_CALC  = 2'h3,
		ST_DONE  = 2'h2
	} fco_state_type;

	// Per-link parameters reported by the terminal
	typedef struct packed {
		logic [2:0]        idx;
		logic [CHIP_W-1:0] tm;
		logic [7:0]        off;
	} fco_link_type;

	// Offsets for one link
	typedef struct packed {
		logic [2:0]        idx;
		logic [CHIP_W-1:0] chip;
		logic [7:0]        frame;
	} fco_result_type;

endpackage

// ---- verilog/fco_top.sv ----
// Overview of operation
// - Common channels in common states use frame offset zero.
// - FDD one link: frame*38400+chip = DOFF*512, optionally +256.
// - TDD one link: frame offset equals DOFF, delivered to serving cell.
// - TDD common channel frame offset stays zero in common state.
// - FDD several links: add OFF_k*38400+Tm_k, deliver per cell.
// - FDD target uses OFF/Tm target, else falls back to single link.
// - TDD target frame offset is OFF target, else DOFF.
// - Inter-RAN entry reuses FDD formulas; TDD takes OFF as zero.
// - Common states load CFN from SFN, mod 256 except paging.
// - Common CFN steps once per frame mod 256; paging keeps SFN.
`timescale 1ns/1ps
module fco_top
	import fco_pkg::*;
#(
	parameter int SFN_MOD = 4096
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	// Frame timing
	input  wire logic                   i_frame_tick,
	// Register port
	input  wire logic [7:0]             i_addr,
	input  wire logic [31:0]            i_wr_data,
	input  wire logic                   i_wr_en,
	input  wire logic                   i_rd_en,
	output logic      [31:0]            o_rd_data,
	// Offsets toward the base station
	output logic      [7:0]             o_frame_offset,
	output logic      [fco_pkg::CHIP_W-1:0] o_chip_offset,
	output logic      [2:0]             o_link_idx,
	output logic                        o_deliver,
	output logic                        o_busy,
	// Synchronisation counters
	output logic      [fco_pkg::CFN_W-1:0] o_cfn,
	output logic      [fco_pkg::SFN_W-1:0] o_sfn
);

	import fco_pkg::*;

	// Refuse a frame number range the counters cannot follow
	generate
		if (SFN_MOD < CFN_MOD || SFN_MOD > (1 << SFN_W)
		    || (SFN_MOD % CFN_MOD) != 0) begin : g_bad_sfn
			$error("fco_top: SFN_MOD out of range");
		end
	endgenerate

	logic                ctrl_tdd_reg;
	logic                ctrl_ded_reg;
	logic                ctrl_half_reg;
	logic                ctrl_known_reg;
	logic [DOFF_W-1:0]   doff_reg;
	fco_link_type        link_reg;
	fco_cmd_type         cmd_reg;
	fco_state_type       state_reg;
	fco_result_type      res_reg;
	logic                div_start_reg;
	logic [TOT_W-1:0]    tot_cap_reg;
	logic [TOT_W-1:0]    total;
	logic [7:0]          tdd_frame;
	logic                use_link;
	logic [TOT_W-1:0]    quot;
	logic [CHIP_W-1:0]   rem;
	logic                div_done;
	logic                cmd_take;
	logic                sfn_wr;
	logic                ctrl_wr;
	logic                cfn_load;
	logic [CFN_W-1:0]    cfn_ld_val;
	logic [31:0]         rd_next;

	// Write strobe decode
	always_comb begin
		cmd_take = 1'b0;
		sfn_wr   = 1'b0;
		ctrl_wr  = 1'b0;
		if (!i_wr_en) begin
			cmd_take = 1'b0;
		end else if (i_addr == OFS_CMD) begin
			cmd_take = (state_reg == ST_IDLE)
			    && (i_wr_data[2:0] >= CMD_SINGLE)
			    && (i_wr_data[2:0] <= CMD_INTER_RAN);
		end else if (i_addr == OFS_SFN) begin
			sfn_wr = 1'b1;
		end else if (i_addr == OFS_CTRL) begin
			ctrl_wr = 1'b1;
		end
	end

	// Configuration registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ctrl_tdd_reg   <= 1'b0;
			ctrl_ded_reg   <= 1'b0;
			ctrl_half_reg  <= 1'b0;
			ctrl_known_reg <= 1'b0;
			doff_reg       <= RST_DOFF;
			link_reg       <= '0;
		end else if (i_wr_en) begin
			if (i_addr == OFS_CTRL) begin
				ctrl_tdd_reg   <= i_wr_data[CTRL_TDD];
				ctrl_ded_reg   <= i_wr_data[CTRL_DED];
				ctrl_half_reg  <= i_wr_data[CTRL_HALF];
				ctrl_known_reg <= i_wr_data[CTRL_KNOWN];
			end else if (i_addr == OFS_DOFF) begin
				doff_reg <= i_wr_data[DOFF_W-1:0];
			end else if (i_addr == OFS_LINK) begin
				link_reg <= i_wr_data[$bits(fco_link_type)-1:0];
			end
		end
	end

	// Chip total for the FDD cases
	always_comb begin
		use_link = (cmd_reg == CMD_MULTI)
		    || (cmd_reg == CMD_INTER_RAN)
		    || (cmd_reg == CMD_TARGET && ctrl_known_reg);
		total = (TOT_W'(doff_reg) << DOFF_SHIFT)
		    + (use_link ? (TOT_W'(link_reg.off) * CHIPS_PER_FRAME
		    + TOT_W'(link_reg.tm)) : '0)
		    + (ctrl_half_reg ? HALF_STEP : '0);
	end

	// TDD frame offset; inter-RAN takes OFF as zero
	always_comb begin
		if (cmd_reg == CMD_TARGET && ctrl_known_reg) begin
			tdd_frame = link_reg.off;
		end else begin
			tdd_frame = 8'(doff_reg);
		end
	end

	// Split the total into whole frames and chips
	fco_divider #(
		.W       (TOT_W),
		.DW      (CHIP_W),
		.DIVISOR (int'(CHIPS_PER_FRAME))
	) u_div (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_start    (div_start_reg),
		.i_dividend (tot_cap_reg),
		.o_quot     (quot),
		.o_rem      (rem),
		.o_done     (div_done)
	);

	// Calculation sequencer
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_reg     <= ST_IDLE;
			cmd_reg       <= CMD_NONE;
			res_reg       <= '0;
			div_start_reg <= 1'b0;
			tot_cap_reg   <= '0;
			o_busy        <= 1'b0;
		end else begin
			div_start_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (cmd_take) begin
						cmd_reg   <= fco_cmd_type'(i_wr_data[2:0]);
						state_reg <= ST_START;
						o_busy    <= 1'b1;
					end
				end
				ST_START: begin
					res_reg.idx <= link_reg.idx;
					if (ctrl_tdd_reg) begin
						res_reg.frame <= tdd_frame;
						res_reg.chip  <= '0;
						state_reg     <= ST_DONE;
					end else begin
						tot_cap_reg   <= total;
						div_start_reg <= 1'b1;
						state_reg     <= ST_CALC;
					end
				end
				ST_CALC: begin
					if (div_done) begin
						res_reg.frame <= quot[7:0];
						res_reg.chip  <= rem;
						state_reg     <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_reg <= ST_IDLE;
					o_busy    <= 1'b0;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Hand offsets to the base station of the addressed cell
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_frame_offset <= 8'h00;
			o_chip_offset  <= '0;
			o_link_idx     <= 3'h0;
			o_deliver      <= 1'b0;
		end else begin
			o_deliver <= (state_reg == ST_DONE);
			if (state_reg == ST_DONE) begin
				o_frame_offset <= ctrl_ded_reg ? res_reg.frame
				    : CMN_FRAME_OFS;
				o_chip_offset  <= res_reg.chip;
				o_link_idx     <= res_reg.idx;
			end
		end
	end

	// Reload the common CFN on leaving dedicated state or on a new SFN written in common state
	always_comb begin
		cfn_load   = (ctrl_wr && ctrl_ded_reg && !i_wr_data[CTRL_DED])
		    || (sfn_wr && !ctrl_ded_reg);
		if (sfn_wr) begin
			cfn_ld_val = i_wr_data[CFN_W-1:0];
		end else begin
			cfn_ld_val = o_sfn[CFN_W-1:0]
			    + (i_frame_tick ? 8'h01 : 8'h00);
		end
	end

	// Cell frame number; paging CFN uses its full range
	fco_counter #(
		.W   (SFN_W),
		.MOD (SFN_MOD)
	) u_sfn (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_load     (sfn_wr),
		.i_load_val (i_wr_data[SFN_W-1:0]),
		.i_step     (i_frame_tick),
		.o_count    (o_sfn)
	);

	// Common and shared channel CFN, 8 bits wide
	fco_counter #(
		.W   (CFN_W),
		.MOD (CFN_MOD)
	) u_cfn (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_load     (cfn_load),
		.i_load_val (cfn_ld_val),
		.i_step     (i_frame_tick),
		.o_count    (o_cfn)
	);

	// Read multiplexer
	always_comb begin
		rd_next = 32'h0000_0000;
		if (i_addr == OFS_CTRL) begin
			rd_next = {28'h0, ctrl_known_reg, ctrl_half_reg,
			    ctrl_ded_reg, ctrl_tdd_reg};
		end else if (i_addr == OFS_DOFF) begin
			rd_next = {22'h0, doff_reg};
		end else if (i_addr == OFS_LINK) begin
			rd_next = {5'h00, link_reg};
		end else if (i_addr == OFS_CMD) begin
			rd_next = {29'h0, cmd_reg};
		end else if (i_addr == OFS_STATUS) begin
			rd_next = {16'h0, CMN_FRAME_OFS, 5'h00, state_reg,
			    o_busy};
		end else if (i_addr == OFS_RESULT) begin
			rd_next = {5'h00, res_reg};
		end else if (i_addr == OFS_SFN) begin
			rd_next = {20'h0, o_sfn};
		end else if (i_addr == OFS_CFN) begin
			rd_next = {24'h0, o_cfn};
		end
	end

	// Read data stand for one cycle only
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rd_data <= 32'h0000_0000;
		end else begin
			o_rd_data <= i_rd_en ? rd_next : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	// Frame offsets delivered while common are zero
	a_cmn_frame_zero: assert property (
		o_deliver && !$past(ctrl_ded_reg) |-> o_frame_offset == 8'h00)
		else $error("common state frame offset not zero");

	// FDD single link frames and chips add back to DOFF chips
	a_fdd_single_sum: assert property (
		div_start_reg && cmd_reg == CMD_SINGLE |-> tot_cap_reg ==
		(TOT_W'($past(doff_reg)) << DOFF_SHIFT)
		+ ($past(ctrl_half_reg) ? HALF_STEP : '0))
		else $error("single link chip total wrong");

	// Divider answer recombines to the captured total
	a_fdd_split_ok: assert property (
		state_reg == ST_CALC && div_done && tot_cap_reg < FO_WRAP_CHIPS
		|=> TOT_W'(res_reg.frame) * CHIPS_PER_FRAME
		+ TOT_W'(res_reg.chip) == tot_cap_reg
		&& TOT_W'(res_reg.chip) < CHIPS_PER_FRAME)
		else $error("frame and chip split wrong");

	// TDD single link takes DOFF
	a_tdd_single_doff: assert property (
		state_reg == ST_START && ctrl_tdd_reg && cmd_reg == CMD_SINGLE
		|=> res_reg.frame == 8'($past(doff_reg)) ##1 o_deliver)
		else $error("tdd single link offset wrong");

	// TDD common offset zero in common state
	a_tdd_cmn_zero: assert property (
		o_deliver && $past(ctrl_tdd_reg) && !$past(ctrl_ded_reg)
		|-> o_frame_offset == 8'h00)
		else $error("tdd common frame offset not zero");

	// FDD target without known offset falls back to single link
	a_fdd_target_fb: assert property (
		div_start_reg && cmd_reg == CMD_TARGET && !$past(ctrl_known_reg)
		|-> tot_cap_reg == (TOT_W'($past(doff_reg)) << DOFF_SHIFT)
		+ ($past(ctrl_half_reg) ? HALF_STEP : '0))
		else $error("fdd target fallback wrong");

	// TDD target uses known offset, else DOFF
	a_tdd_target_sel: assert property (
		state_reg == ST_START && ctrl_tdd_reg && cmd_reg == CMD_TARGET
		|=> res_reg.frame == ($past(ctrl_known_reg) ? $past(link_reg.off)
		: 8'($past(doff_reg))))
		else $error("tdd target offset wrong");

	// TDD inter-RAN entry ignores OFF
	a_tdd_inter_ran: assert property (
		state_reg == ST_START && ctrl_tdd_reg && cmd_reg == CMD_INTER_RAN
		|=> res_reg.frame == 8'($past(doff_reg)))
		else $error("tdd inter-ran offset wrong");

	// Reload takes the frame number
	a_cfn_reload: assert property (
		cfn_load |=> o_cfn == $past(cfn_ld_val))
		else $error("cfn reload wrong");

	// One step per frame with natural wrap
	a_cfn_step: assert property (
		i_frame_tick && !cfn_load |=> o_cfn == 8'($past(o_cfn) + 8'h01))
		else $error("cfn step wrong");

	// Each accepted command is answered in bounded time
	a_cmd_answered: assert property (
		cmd_take |-> ##[3:29] o_deliver)
		else $error("command not answered");

	c_tdd_deliver: cover property (o_deliver && ctrl_tdd_reg);
	c_fdd_multi: cover property (
		state_reg == ST_DONE && cmd_reg == CMD_MULTI && !ctrl_tdd_reg);
	c_cfn_wrap: cover property (o_cfn == 8'hFF && i_frame_tick);
	c_cmd_refused: cover property (
		i_wr_en && i_addr == OFS_CMD && state_reg != ST_IDLE);

endmodule
